// ==== hcmc_defines.vh ====
// Register map, field codes and timing constants of the heat/cool change-over block
`ifndef HCMC_DEFINES_VH
`define HCMC_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define HCMC_OFS_CFG      8'h00
`define HCMC_OFS_TEMP     8'h04
`define HCMC_OFS_SETP     8'h08
`define HCMC_OFS_CMD      8'h0c
`define HCMC_OFS_STAT     8'h10
`define HCMC_OFS_IRQ      8'h14
`define HCMC_OFS_MASK     8'h18
`define HCMC_OFS_CORX     8'h1c
`define HCMC_OFS_NVM      8'h20

// ****************************************************************
// Configuration fields
// ****************************************************************
`define HCMC_CFG_OPM_LO   0
`define HCMC_CFG_OPM_HI   1
`define HCMC_CFG_ADDL     2
`define HCMC_CFG_OBJCO    3
`define HCMC_CFG_ABSSP    4
`define HCMC_CFG_TXCMD    5
`define HCMC_CFG_PRM_LO   6
`define HCMC_CFG_PRM_HI   7
`define HCMC_CFG_INIT     8
`define HCMC_CFG_CYC_LO   16
`define HCMC_CFG_CYC_HI   23
`define HCMC_CFG_RST      32'h0000_0000

// Operating modes and post-reset modes
`define HCMC_OPM_HEAT     2'h0
`define HCMC_OPM_COOL     2'h1
`define HCMC_OPM_MIXED    2'h2
`define HCMC_PRM_HEAT     2'h0
`define HCMC_PRM_COOL     2'h1
`define HCMC_PRM_PREV     2'h2

// Interrupt event bits
`define HCMC_EV_MODE      0
`define HCMC_EV_TX        1
`define HCMC_EV_NVM       2
`define HCMC_EV_RX        3
`define HCMC_NEV          4

// ****************************************************************
// Timing: cyclic repeat base unit, 1 ms at 125 MHz
// ****************************************************************
`define HCMC_BASE_NS      1000000
`define HCMC_CLK_NS       8
`define HCMC_BASE_CYC     (`HCMC_BASE_NS / `HCMC_CLK_NS)

`endif

// ==== hcmc_cyclic.v ====
// Periodic repeat tick generator for the change-over object
`include "hcmc_defines.vh"
module hcmc_cyclic #(
   parameter BASE_CYC = `HCMC_BASE_CYC // Cycles per repeat unit
) (
   input  wire       hclk,
   input  wire       hresetn,
   input  wire       enable,        // Automatic change-over active
   input  wire [7:0] factor,        // Repeat factor, zero disables
   input  wire       restart,       // Restart period, tied low by the top level
   output reg        tick           // One-cycle repeat request
);
   reg [23:0] base_reg;             // Unit prescaler
   reg [7:0]  unit_reg;             // Units elapsed

   // ****************************************************************
   // Prescaler and unit counter
   // ****************************************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         base_reg <= 24'h000000;
         unit_reg <= 8'h00;
         tick     <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (!enable || factor == 8'h00 || restart) begin
            base_reg <= 24'h000000;
            unit_reg <= 8'h00;
         end else if (base_reg == BASE_CYC - 1) begin
            base_reg <= 24'h000000;
            if (unit_reg == factor - 8'h01) begin
               unit_reg <= 8'h00;
               tick     <= 1'b1;             // Factor sets period
            end else begin
               unit_reg <= unit_reg + 8'h01;
            end
         end else begin
            base_reg <= base_reg + 24'h000001;
         end
      end
   end
endmodule // hcmc_cyclic

// ==== hcmc_decide.v ====
// Combinational heating/cooling demand decision from temperature and setpoints
module hcmc_decide (
   input  wire [15:0] temp,         // Room temperature, signed 0.01 K
   input  wire [15:0] heat_sp,      // Heating setpoint
   input  wire [15:0] cool_sp,      // Cooling setpoint
   output wire        below_heat,   // Room colder than heating setpoint
   output wire        above_cool,   // Room warmer than cooling setpoint
   output wire        in_band       // Inside the deadband
);
   // Signed compare: rooms may read below zero
   assign below_heat = $signed(temp) < $signed(heat_sp);
   assign above_cool = $signed(temp) > $signed(cool_sp);
   assign in_band    = !below_heat && !above_cool;
endmodule // hcmc_decide

// ==== hcmc_top.v ====
// Heat/cool operating mode and change-over logic with AHB-Lite register slave
//
// Behaviour
// - One command value; two with additional level
// - Basic and additional values from deviation, sent
// - Heat/cool messages follow the basic level
// - Automatic: no demand inside the deadband
// - Change-over object: one heating, zero cooling
// - Mode-change reporting sends on real switch
// - Command-change reporting sends mode on change
// - Deadband keeps last active mode in object
// - Cyclic repeat only when factor above zero
// - Object mode from received object, deadband ignored
// - Object cleared at reset, post-reset mode applied
// - Object mode starts at post-reset mode
// - Restore-previous stores each change nonvolatile
// - Absolute setpoints force object change-over
`include "hcmc_defines.vh"
module hcmc_top #(
   parameter BASE_CYC = `HCMC_BASE_CYC // Cycles per cyclic repeat unit
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   output reg         irq,
   output reg         heat_msg,
   output reg         cool_msg,
   output reg         co_tx_valid,
   output reg         co_tx_value,
   output reg  [7:0]  cmd_basic,
   output reg  [7:0]  cmd_addl,
   output reg         cmd_valid,
   output reg         nvm_wr,
   output reg         nvm_data
);
   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [31:0] cfg_reg;              // Configuration
   reg [15:0] temp_reg;             // Actual temperature
   reg [15:0] heat_sp_reg;          // Heating setpoint
   reg [15:0] cool_sp_reg;          // Cooling setpoint
   reg [7:0]  gain_reg;             // Deviation gain per level
   reg [3:0]  irq_reg;              // Sticky events
   reg [3:0]  mask_reg;             // Event mask
   reg        nvm_mode_reg;         // Stored mode, retained by software
   reg        mode_reg;             // Active mode, 1 heating
   reg        co_obj_reg;           // Change-over object value
   reg        active_reg;           // Demand currently present
   reg        init_done_reg;        // Post-reset mode applied
   reg [7:0]  cmd_last_reg;         // Last sent basic value
   reg        rx_pulse_reg;         // Object update received

   // Address phase capture
   reg        dp_valid_reg;
   reg        dp_write_reg;
   reg [7:0]  dp_addr_reg;

   // ****************************************************************
   // Configuration decode
   // ****************************************************************
   wire [1:0] opm      = cfg_reg[`HCMC_CFG_OPM_HI:`HCMC_CFG_OPM_LO];
   wire       addl_en  = cfg_reg[`HCMC_CFG_ADDL];
   wire       abs_sp   = cfg_reg[`HCMC_CFG_ABSSP];
   wire       obj_co   = cfg_reg[`HCMC_CFG_OBJCO] | abs_sp; // Forced by absolute
   wire       tx_cmd   = cfg_reg[`HCMC_CFG_TXCMD];
   wire [1:0] prm      = cfg_reg[`HCMC_CFG_PRM_HI:`HCMC_CFG_PRM_LO];
   wire       init_req = cfg_reg[`HCMC_CFG_INIT];
   wire [7:0] cyc_fac  = cfg_reg[`HCMC_CFG_CYC_HI:`HCMC_CFG_CYC_LO];
   wire       mixed    = (opm == `HCMC_OPM_MIXED);
   wire       auto_co  = mixed && !obj_co;

   // Absolute setpoints leave no deadband,
   // so the object path is forced for them.
   // Automatic change-over needs mixed mode.

   // Post-reset mode choice
   wire prm_mode = (prm == `HCMC_PRM_HEAT) ? 1'b1 :
                   (prm == `HCMC_PRM_COOL) ? 1'b0 : nvm_mode_reg;

   // ****************************************************************
   // Demand decision
   // ****************************************************************
   wire below_heat;
   wire above_cool;
   wire in_band;
   hcmc_decide u_decide (
      .temp       (temp_reg),
      .heat_sp    (heat_sp_reg),
      .cool_sp    (cool_sp_reg),
      .below_heat (below_heat),
      .above_cool (above_cool),
      .in_band    (in_band)
   );

   // Software writes to the object register count as received updates
   wire bus_wr  = dp_valid_reg && dp_write_reg;
   wire rx_wr   = bus_wr && dp_addr_reg == `HCMC_OFS_CORX;

   // ****************************************************************
   // Mode selection
   // ****************************************************************
   // No demand until initialisation ends.
   // Inside the deadband the mode is kept,
   // so the object holds the last mode.
   // Object updates act in the data phase
   // of the write, not a cycle later.
   // Single modes pin the mode outright.

   // Next mode per operating mode
   reg mode_next;
   reg active_next;
   always @* begin
      mode_next   = mode_reg;
      active_next = 1'b1;
      if (!init_done_reg) begin
         active_next = 1'b0;
      end else if (opm == `HCMC_OPM_HEAT) begin
         mode_next   = 1'b1;
         active_next = below_heat;
      end else if (opm == `HCMC_OPM_COOL) begin
         mode_next   = 1'b0;
         active_next = above_cool;
      end else if (obj_co) begin
         if (rx_wr)                               // Only on update
            mode_next = hwdata[0];                // 1 heat, 0 cool
         active_next = mode_next ? below_heat : above_cool; // Band ignored
      end else begin
         if (below_heat)
            mode_next = 1'b1;
         else if (above_cool)
            mode_next = 1'b0;
         active_next = !in_band;                  // Hold mode in band
      end
   end

   // ****************************************************************
   // Command values
   // ****************************************************************
   // Deviation in the demand direction;
   // a negative result means no demand.
   // Values follow the registered mode, so
   // a switch straight from one demand to the other
   // moves the value twice in two cycles; each move is a telegram.
   // Gain saturates rather than wraps.

   // Deviation magnitude, clamped to 8 bits
   wire [16:0] dev_h = {temp_reg[15], temp_reg} - {heat_sp_reg[15], heat_sp_reg};
   wire [16:0] dev_c = {cool_sp_reg[15], cool_sp_reg} - {temp_reg[15], temp_reg};
   wire [16:0] dev   = mode_reg ? (17'h0 - dev_h) : (17'h0 - dev_c);
   wire [15:0] prod  = dev[7:0] * gain_reg;
   wire [7:0]  lvl_b = (dev[16] || !active_reg) ? 8'h00 :
                       (|dev[15:8] || |prod[15:8]) ? 8'hff : prod[7:0];
   wire [7:0]  lvl_a = (lvl_b == 8'hff) ? 8'hff : {1'b0, lvl_b[7:1]}; // Second level half of basic, 8'hff when basic saturates

   // Event strobes, one cycle each.
   // Reporting choice picks the trigger;
   // cyclic repeats share the same strobe.
   // Mode change is blind before init.
   wire mode_change = init_done_reg && mode_next != mode_reg;
   wire cyc_tick;
   wire cmd_change  = lvl_b != cmd_last_reg;
   wire tx_event    = auto_co && ((tx_cmd ? cmd_change : mode_change) || cyc_tick);


   // Period restarts only when repeat is off;
   // event telegrams leave the period alone.
   hcmc_cyclic #(.BASE_CYC(BASE_CYC)) u_cyclic (
      .hclk    (hclk),
      .hresetn (hresetn),
      .enable  (auto_co),
      .factor  (cyc_fac),
      .restart (1'b0),
      .tick    (cyc_tick)
   );

   // ****************************************************************
   // Mode, messages and transmissions
   // ****************************************************************
   // Strobes fall every cycle unless raised.
   // Messages run one cycle behind state.
   // The store strobe fires only when the
   // post-reset mode is restore-previous,
   // to spare the nonvolatile write budget.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_reg      <= 1'b0;
         co_obj_reg    <= 1'b0;                   // Cleared at reset
         active_reg    <= 1'b0;
         init_done_reg <= 1'b0;
         heat_msg      <= 1'b0;
         cool_msg      <= 1'b0;
         co_tx_valid   <= 1'b0;
         co_tx_value   <= 1'b0;
         cmd_basic     <= 8'h00;
         cmd_addl      <= 8'h00;
         cmd_valid     <= 1'b0;
         cmd_last_reg  <= 8'h00;
         nvm_wr        <= 1'b0;
         nvm_data      <= 1'b0;
         rx_pulse_reg  <= 1'b0;
      end else begin
         co_tx_valid  <= 1'b0;
         cmd_valid    <= 1'b0;
         nvm_wr       <= 1'b0;
         rx_pulse_reg <= rx_wr && obj_co;
         if (!init_done_reg) begin
            if (init_req) begin                   // End of initialisation
               init_done_reg <= 1'b1;
               mode_reg      <= prm_mode;
            end
         end else begin
            mode_reg   <= mode_next;
            active_reg <= active_next;
            if (obj_co && rx_wr)
               co_obj_reg <= hwdata[0];
            else if (auto_co)
               co_obj_reg <= mode_next;           // Last mode held
         end
         // Messages follow basic level only
         heat_msg <= active_reg && mode_reg;
         cool_msg <= active_reg && !mode_reg;
         // Two values only with additional level
         if (cmd_change) begin
            cmd_last_reg <= lvl_b;
            cmd_basic    <= lvl_b;
            cmd_addl     <= addl_en ? lvl_a : 8'h00;
            cmd_valid    <= 1'b1;
         end
         if (tx_event) begin
            co_tx_valid <= 1'b1;
            co_tx_value <= tx_cmd ? mode_reg : mode_next;
         end
         if (mode_change && prm == `HCMC_PRM_PREV) begin
            nvm_wr   <= 1'b1;
            nvm_data <= mode_next;
         end
      end
   end

   // ****************************************************************
   // AHB-Lite slave, zero wait states, always OKAY
   // ****************************************************************
   // Ready is a constant one, the response
   // stays OKAY; address and direction are
   // kept for the data phase.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_addr_reg  <= 8'h00;
         hreadyout    <= 1'b1;
         hresp        <= 1'b0;
      end else if (hready) begin
         dp_valid_reg <= hsel && htrans[1];
         dp_write_reg <= hwrite;
         dp_addr_reg  <= haddr;
      end
   end

   // Events: mode change, telegram, store,
   // object received.
   wire rd_irq = dp_valid_reg && !dp_write_reg && dp_addr_reg == `HCMC_OFS_IRQ;
   wire [3:0] ev = {rx_pulse_reg, nvm_wr, co_tx_valid, mode_change};

   // The event register clears in the data
   // phase of its read; an event in that
   // same cycle survives; one set in the address phase is cleared unread.
   // A software load of the stored mode
   // wins over a hardware store.

   // Register writes, sticky events: set beats clear-on-read
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_reg      <= `HCMC_CFG_RST;
         temp_reg     <= 16'h0000;
         heat_sp_reg  <= 16'h0000;
         cool_sp_reg  <= 16'h0000;
         gain_reg     <= 8'h01;
         mask_reg     <= 4'h0;
         irq_reg      <= 4'h0;
         nvm_mode_reg <= 1'b0;
         irq          <= 1'b0;
      end else begin
         irq_reg <= (rd_irq ? 4'h0 : irq_reg) | ev;
         irq     <= |(((rd_irq ? 4'h0 : irq_reg) | ev) & mask_reg);
         if (nvm_wr)
            nvm_mode_reg <= nvm_data;
         if (bus_wr) begin
            case (dp_addr_reg)
               `HCMC_OFS_CFG:  cfg_reg <= hwdata;
               `HCMC_OFS_TEMP: temp_reg <= hwdata[15:0];
               `HCMC_OFS_SETP: begin
                  heat_sp_reg <= hwdata[15:0];
                  cool_sp_reg <= hwdata[31:16];
               end
               `HCMC_OFS_CMD:  gain_reg <= hwdata[7:0];
               `HCMC_OFS_MASK: mask_reg <= hwdata[3:0];
               `HCMC_OFS_NVM:  nvm_mode_reg <= hwdata[0];
               default: ;
            endcase
         end
      end
   end

   // Loaded at the address phase edge and
   // stands until the next read; unmapped
   // offsets read as zero.

   // Read data in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr)
            `HCMC_OFS_CFG:  hrdata <= cfg_reg;
            `HCMC_OFS_TEMP: hrdata <= {16'h0000, temp_reg};
            `HCMC_OFS_SETP: hrdata <= {cool_sp_reg, heat_sp_reg};
            `HCMC_OFS_CMD:  hrdata <= {8'h00, cmd_addl, cmd_basic, gain_reg};
            `HCMC_OFS_STAT: hrdata <= {26'h0, init_done_reg, active_reg, cool_msg,
                                       heat_msg, co_obj_reg, mode_reg};
            `HCMC_OFS_IRQ:  hrdata <= {28'h0, irq_reg};
            `HCMC_OFS_MASK: hrdata <= {28'h0, mask_reg};
            `HCMC_OFS_CORX: hrdata <= {31'h0, co_obj_reg};
            `HCMC_OFS_NVM:  hrdata <= {31'h0, nvm_mode_reg};
            default:        hrdata <= 32'h00000000;
         endcase
      end
   end
endmodule // hcmc_top

// ==== hcmc_chk.sv ====
// Concurrent checker for the heat/cool change-over block ports
module hcmc_chk #(
   parameter BASE_CYC = 4                  // Cycles per cyclic repeat unit
) (
   input logic        hclk,
   input logic        hresetn,
   input logic        hsel,
   input logic [7:0]  haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic        hready,
   input logic [31:0] hrdata,
   input logic        hreadyout,
   input logic        hresp,
   input logic        heat_msg,
   input logic        cool_msg,
   input logic        co_tx_valid,
   input logic        co_tx_value,
   input logic [7:0]  cmd_basic,
   input logic [7:0]  cmd_addl,
   input logic        cmd_valid,
   input logic        nvm_wr
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // Properties, one clock domain
   // ****************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Read address phase beyond the last register
   sequence s_rd_miss;
      hsel && hready && htrans[1] && !hwrite && (haddr >= 8'h24);
   endsequence
   sequence s_tx; co_tx_valid; endsequence
   property p_rd_miss; s_rd_miss |=> (hrdata == 32'h0); endproperty
   property p_okay; hresp == 1'b0; endproperty
   property p_ready; hreadyout == 1'b1; endproperty
   property p_excl; !(heat_msg && cool_msg); endproperty
   property p_addl; cmd_addl <= cmd_basic; endproperty
   // Back-to-back telegrams only ride on a command-value change
   property p_tx_pulse; s_tx |=> !co_tx_valid || cmd_valid; endproperty
   property p_nvm_pulse; nvm_wr |=> !nvm_wr; endproperty
   property p_rst_out; $rose(hresetn) |-> !co_tx_value && !heat_msg && !cool_msg; endproperty
   a_rd_miss: assert property (p_rd_miss) else $error("unmapped read not zero");
   a_okay: assert property (p_okay) else $error("response not okay");
   a_ready: assert property (p_ready) else $error("wait state inserted");
   a_excl: assert property (p_excl) else $error("heat and cool messages together");
   a_addl: assert property (p_addl) else $error("additional value above basic");
   a_tx_pulse: assert property (p_tx_pulse) else $error("telegram repeat without value change");
   a_nvm_pulse: assert property (p_nvm_pulse) else $error("store pulse too long");
   a_rst_out: assert property (p_rst_out) else $error("outputs not clear after reset");
   c_tx: cover property (s_tx);
endmodule // hcmc_chk

bind hcmc_top hcmc_chk #(.BASE_CYC(BASE_CYC)) u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .heat_msg(heat_msg),
   .cool_msg(cool_msg), .co_tx_valid(co_tx_valid), .co_tx_value(co_tx_value),
   .cmd_basic(cmd_basic), .cmd_addl(cmd_addl), .cmd_valid(cmd_valid), .nvm_wr(nvm_wr));

// ==== hcmc_bus_model.sv ====
// Far-side model: actuators and bus devices receiving telegrams
module hcmc_bus_model (
   input  logic       hclk,
   input  logic       co_tx_valid,
   input  logic       co_tx_value,
   input  logic       cmd_valid,
   input  logic       nvm_wr,
   output int         tx_cnt,
   output logic       tx_last,
   output int         cmd_cnt,
   output int         nvm_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // Telegram capture
   // ****************************************************************
   initial begin
      tx_cnt = 0;
      tx_last = 1'b1;                      // Inverse of the cleared object
      cmd_cnt = 0;
      nvm_cnt = 0;
   end
   // Counts never reset, so the bench works with differences
   always @(posedge hclk) begin
      if (co_tx_valid === 1'b1) begin      // Change-over telegram
         tx_cnt <= tx_cnt + 1;
         tx_last <= co_tx_value;
      end
      if (cmd_valid === 1'b1) cmd_cnt <= cmd_cnt + 1; // Command telegram
      if (nvm_wr === 1'b1) nvm_cnt <= nvm_cnt + 1;    // Stored mode
   end
endmodule // hcmc_bus_model

// ==== test_heat_cool_mode_changeover.sv ====
// Self-checking bench for the heat/cool change-over block
`include "hcmc_defines.vh"
module test_heat_cool_mode_changeover;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, r;
   logic        hreadyout, hresp, irq, heat_msg, cool_msg, co_tx_valid, co_tx_value;
   logic [7:0]  cmd_basic, cmd_addl;
   logic        cmd_valid, nvm_wr, nvm_data, tx_last;
   wire         hready = hreadyout;         // Single slave drives the bus ready
   int          error_cnt = 0, checks = 0, tx_cnt, cmd_cnt, nvm_cnt, t0, n0, c0;
   hcmc_top #(.BASE_CYC(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .heat_msg(heat_msg),
      .cool_msg(cool_msg), .co_tx_valid(co_tx_valid), .co_tx_value(co_tx_value),
      .cmd_basic(cmd_basic), .cmd_addl(cmd_addl), .cmd_valid(cmd_valid), .nvm_wr(nvm_wr),
      .nvm_data(nvm_data));
   hcmc_bus_model u_bus (.hclk(hclk), .co_tx_valid(co_tx_valid), .co_tx_value(co_tx_value),
      .cmd_valid(cmd_valid), .nvm_wr(nvm_wr), .tx_cnt(tx_cnt), .tx_last(tx_last),
      .cmd_cnt(cmd_cnt), .nvm_cnt(nvm_cnt));
   // ****************************************************************
   // Clock, bus tasks and comparison
   // ****************************************************************
   always #4 hclk = ~hclk;                  // 125 MHz
   task automatic print_verdict();
      $display("error_cnt=%0d checks=%0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Address phase held until ready, then data phase until ready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge hclk);
         hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
         do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 20);
         htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
         do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 40);
         r = hrdata;                        // Read data taken at the closing edge
         if (n >= 40) begin error_cnt++; print_verdict(); end
      end
   endtask
   task automatic settle(); repeat (12) @(posedge hclk); endtask
   task automatic temp(input logic [15:0] t); bus(1'b1, `HCMC_OFS_TEMP, {16'h0, t}); settle();
   endtask
   // Config word: opmode, {txcmd,abs,obj,addl}, post-reset mode, cyclic factor, init set
   function automatic logic [31:0] cfg(input logic [1:0] o, input logic [3:0] f,
                                       input logic [1:0] p, input logic [7:0] c);
      return {8'h00, c, 7'h00, 1'b1, p, f, o};
   endfunction
   // Reset, 4 K deadband from 20.00 to 24.00, gain one, mode event unmasked
   task automatic setup(input logic [31:0] c);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b1, `HCMC_OFS_SETP, 32'h0960_07d0);
      bus(1'b1, `HCMC_OFS_CMD, 32'h1);
      bus(1'b1, `HCMC_OFS_MASK, 32'h1);
      bus(1'b1, `HCMC_OFS_CFG, c);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 0; hwdata = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, `HCMC_OFS_CORX, 32'h0); chk(r[0], 1'b0);
      bus(1'b0, 8'h40, 32'h0); chk(r, 32'h0);
      // Automatic change-over, report on mode change, no cyclic repeat
      setup(cfg(`HCMC_OPM_MIXED, 4'h0, `HCMC_PRM_HEAT, 8'h00));
      temp(16'h0708);
      chk(heat_msg, 1'b1);
      chk(cool_msg, 1'b0);
      chk(cmd_basic, 8'hc8);
      chk(cmd_addl, 8'h00);
      t0 = tx_cnt;
      n0 = nvm_cnt;
      c0 = cmd_cnt;
      temp(16'h0898);
      chk({heat_msg, cool_msg}, 2'b00);
      chk(tx_cnt, t0);
      chk(cmd_cnt, c0 + 1);
      chk(cmd_basic, 8'h00);
      temp(16'h0a28);
      chk(cool_msg, 1'b1);
      chk(tx_cnt, t0 + 1);
      chk(tx_last, 1'b0);
      chk(irq, 1'b1);
      bus(1'b0, `HCMC_OFS_IRQ, 32'h0); chk(r[0], 1'b1);
      bus(1'b0, `HCMC_OFS_IRQ, 32'h0); chk(r[0], 1'b0);
      settle(); chk(irq, 1'b0);
      temp(16'h0898); chk(tx_cnt, t0 + 1);
      temp(16'h0708); chk(tx_last, 1'b1);
      chk(tx_cnt, t0 + 2);
      repeat (40) @(posedge hclk); chk(tx_cnt, t0 + 2);
      chk(nvm_cnt, n0);
      // Cyclic factor two: one repeat every eight cycles
      bus(1'b1, `HCMC_OFS_CFG, cfg(`HCMC_OPM_MIXED, 4'h0, `HCMC_PRM_HEAT, 8'h02));
      t0 = tx_cnt;
      repeat (40) @(posedge hclk); chk(tx_cnt - t0 >= 4 && tx_cnt - t0 <= 6, 1'b1);
      // Report on command change, restore-previous storage
      setup(cfg(`HCMC_OPM_MIXED, 4'h8, `HCMC_PRM_PREV, 8'h00));
      temp(16'h0708);
      t0 = tx_cnt;
      n0 = nvm_cnt;
      temp(16'h06a4); chk(tx_cnt > t0, 1'b1);
      chk(tx_last, 1'b1);
      temp(16'h0a28); chk(nvm_cnt > n0, 1'b1);
      chk(nvm_data, 1'b0);
      bus(1'b0, `HCMC_OFS_NVM, 32'h0); chk(r[0], 1'b0);
      t0 = tx_cnt;
      temp(16'h0898); chk(tx_cnt > t0, 1'b1);
      chk(tx_last, 1'b0);
      // Object change-over starting in cooling
      setup(cfg(`HCMC_OPM_MIXED, 4'h2, `HCMC_PRM_COOL, 8'h00));
      temp(16'h0708); chk(heat_msg, 1'b0);
      bus(1'b1, `HCMC_OFS_CORX, 32'h1); settle(); chk(heat_msg, 1'b1);
      temp(16'h0a28); chk(cool_msg, 1'b0);
      bus(1'b1, `HCMC_OFS_CORX, 32'h0); settle(); chk(cool_msg, 1'b1);
      // Absolute setpoints never switch by themselves
      setup(cfg(`HCMC_OPM_MIXED, 4'h4, `HCMC_PRM_HEAT, 8'h00));
      temp(16'h0a28); chk(cool_msg, 1'b0);
      // Single cooling with additional level
      setup(cfg(`HCMC_OPM_COOL, 4'h1, `HCMC_PRM_HEAT, 8'h00));
      temp(16'h0a28); chk(cool_msg, 1'b1);
      chk({cmd_basic, cmd_addl}, 16'hc864);
      print_verdict();
   end
endmodule // test_heat_cool_mode_changeover
